// >>> logic/eip_cfg_filter.sv
// config select filter for the interrupt pin during init mode
`timescale 1ns/100ps
module eip_cfg_filter #(
	parameter int FLT_CYC = eip_pkg::EIP_CFG_FLT_CYC,
	parameter int CNT_W = eip_pkg::EIP_CNT_W
) (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_enable,
	input wire logic i_level,
	output logic o_level
);
	// candidate level and how long it has stood
	logic cand;
	logic [CNT_W-1:0] cnt;
	wire logic same = (i_level == cand);
	wire logic done = (cnt == CNT_W'(FLT_CYC - 1));

	// count while the level is stable, accept after the filter time
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			cand <= 1'b0;
			cnt <= '0;
			o_level <= 1'b0;
		end else if (!i_enable || !same) begin
			cand <= i_level;
			cnt <= '0;
		end else if (done) begin
			// (R15) filtered level accepted
			o_level <= cand;
		end else begin
			cnt <= cnt + CNT_W'(1);
		end
	end

	// (R15) accepted level was stable and the filter enabled in the cycle before the change
	cfg_stable_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R15
		$changed(o_level) |-> $past(same) && $past(i_enable)) else $error("config level taken unfiltered");
endmodule

// >>> logic/eip_pkg.sv
// package with modes, timing constants and widths for the event interrupt pulser
package eip_pkg;
	// operating modes seen by the block
	typedef enum logic [2:0] {
		EIP_MODE_INIT = 3'b000,
		EIP_MODE_NORMAL = 3'b001,
		EIP_MODE_STOP = 3'b010,
		EIP_MODE_SLEEP = 3'b011,
		EIP_MODE_RESTART = 3'b100,
		EIP_MODE_FAILSAFE = 3'b101
	} eip_mode_t;
	// pulser states
	typedef enum logic [1:0] {
		EIP_ST_IDLE = 2'b00,
		EIP_ST_PULSE = 2'b01,
		EIP_ST_GAP = 2'b10
	} eip_state_t;
	localparam int EIP_CLK_MHZ = 50;
	// nominal pulse width and gap in microseconds
	localparam int EIP_PULSE_US = 100;
	localparam int EIP_GAP_US = 100;
	// nominal config select filter time in microseconds
	localparam int EIP_CFG_FLT_US = 10;
	localparam int EIP_PULSE_CYC = EIP_PULSE_US * EIP_CLK_MHZ;
	localparam int EIP_GAP_CYC = EIP_GAP_US * EIP_CLK_MHZ;
	localparam int EIP_CFG_FLT_CYC = EIP_CFG_FLT_US * EIP_CLK_MHZ;
	localparam int EIP_WAKE_W = 8;
	localparam int EIP_FAIL_W = 8;
	localparam int EIP_CNT_W = 16;
	// class selector values
	localparam logic EIP_CLASS_WAKE = 1'b0;
	localparam logic EIP_CLASS_GLOBAL = 1'b1;
endpackage

// >>> logic/eip_pulser.sv
// interrupt pulser: event qualification, pulse and gap timing, status latching
//Contract
// (R01) low pulse of 100 us in normal/stop
// (R02) pin high at least 100 us between pulses
// (R03) pulses never change the operating mode
// (R04) class 0: latched wake bits interrupt
// (R05) wake interrupt only from enabled sources
// (R06) bus timeout masked by own bit only
// (R07) class 1: failure flags also interrupt
// (R08) level status never interrupts nor latches
// (R09) restart/failsafe faults, reset, device status excluded
// (R10) stop entry with wake bits set interrupts
// (R11) status view updates at pulse falling edge
// (R12) flags latched until host clears them
// (R13) host may reread after clearing
// (R14) init mode: pin is config select input
// (R15) config select filtered 10 us
// (R16) events during pulse/gap held pending
`timescale 1ns/100ps
module eip_pulser #(
	parameter int WAKE_W = eip_pkg::EIP_WAKE_W,
	parameter int FAIL_W = eip_pkg::EIP_FAIL_W,
	parameter int PULSE_CYC = eip_pkg::EIP_PULSE_CYC,
	parameter int GAP_CYC = eip_pkg::EIP_GAP_CYC,
	parameter int CFG_FLT_CYC = eip_pkg::EIP_CFG_FLT_CYC
) (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire eip_pkg::eip_mode_t i_mode,
	input wire logic i_int_global,
	input wire logic [WAKE_W-1:0] i_wake_evt_a,
	input wire logic [WAKE_W-1:0] i_wake_evt_b,
	input wire logic [WAKE_W-1:0] i_wake_en_a,
	input wire logic [WAKE_W-1:0] i_wake_en_b,
	input wire logic [WAKE_W-1:0] i_clr_wake_a,
	input wire logic [WAKE_W-1:0] i_clr_wake_b,
	input wire logic i_bus_timeout_flag,
	input wire logic i_bus_timeout_irq_mask,
	input wire logic i_clr_bus_timeout,
	input wire logic [FAIL_W-1:0] i_fail_evt,
	input wire logic [FAIL_W-1:0] i_clr_fail,
	input wire logic i_int_pin,
	output logic o_int_out,
	output logic o_int_oe,
	output logic o_int_pd_en,
	output logic o_cfg_sel,
	output logic [WAKE_W-1:0] o_wake_status_a,
	output logic [WAKE_W-1:0] o_wake_status_b,
	output logic o_bus_timeout_status,
	output logic [FAIL_W-1:0] o_fail_status
);
	localparam int CW = eip_pkg::EIP_CNT_W;
	// latched flags, live state
	logic [WAKE_W-1:0] wk_a;
	logic [WAKE_W-1:0] wk_b;
	logic bto;
	logic [FAIL_W-1:0] fl;
	// flags already reported by a pulse
	logic [WAKE_W-1:0] rep_a;
	logic [WAKE_W-1:0] rep_b;
	logic rep_bto;
	logic [FAIL_W-1:0] rep_fl;
	logic stop_req;
	eip_pkg::eip_state_t state;
	logic [CW-1:0] cnt;
	eip_pkg::eip_mode_t mode_q;

	// (R05) only enabled wake sources qualify
	wire logic [WAKE_W-1:0] q_a = i_wake_evt_a & i_wake_en_a;
	wire logic [WAKE_W-1:0] q_b = i_wake_evt_b & i_wake_en_b;
	// (R09) fail vector carries only interrupt-capable failures
	wire logic [FAIL_W-1:0] fl_new = fl & ~rep_fl;
	// (R04) unreported wake bits
	wire logic wake_new = |(wk_a & ~rep_a) || |(wk_b & ~rep_b);
	// (R06) timeout gated by its own mask, not by class
	wire logic bto_new = bto && !rep_bto && !i_bus_timeout_irq_mask;
	// (R07) failures only in global class
	wire logic fail_new = (i_int_global == eip_pkg::EIP_CLASS_GLOBAL) && |fl_new;
	// (R10) stop entry with wake flags pending
	wire logic stop_entry = (i_mode == eip_pkg::EIP_MODE_STOP) && (mode_q != eip_pkg::EIP_MODE_STOP)
		&& (|wk_a || |wk_b);
	wire logic active_mode = (i_mode == eip_pkg::EIP_MODE_NORMAL) || (i_mode == eip_pkg::EIP_MODE_STOP);
	// (R16) anything pending waits for idle
	wire logic pend = wake_new || bto_new || fail_new || stop_req;
	wire logic fire = (state == eip_pkg::EIP_ST_IDLE) && active_mode && pend;
	wire logic pulse_end = (state == eip_pkg::EIP_ST_PULSE) && (cnt == CW'(PULSE_CYC - 1));
	wire logic gap_end = (state == eip_pkg::EIP_ST_GAP) && (cnt == CW'(GAP_CYC - 1));
	wire logic init_mode = (i_mode == eip_pkg::EIP_MODE_INIT);

	// (R12) latch events; set wins over host clear; (R08) no level status kept
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			wk_a <= '0;
			wk_b <= '0;
			bto <= 1'b0;
			fl <= '0;
		end else begin
			wk_a <= (wk_a & ~i_clr_wake_a) | q_a;
			wk_b <= (wk_b & ~i_clr_wake_b) | q_b;
			bto <= (bto & ~i_clr_bus_timeout) | i_bus_timeout_flag;
			fl <= (fl & ~i_clr_fail) | i_fail_evt;
		end
	end

	// reported marks follow the flags; cleared flags become reportable again
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			rep_a <= '0;
			rep_b <= '0;
			rep_bto <= 1'b0;
			rep_fl <= '0;
		end else if (fire) begin
			rep_a <= wk_a;
			rep_b <= wk_b;
			rep_bto <= bto;
			rep_fl <= fl;
		end else begin
			rep_a <= rep_a & wk_a;
			rep_b <= rep_b & wk_b;
			rep_bto <= rep_bto & bto;
			rep_fl <= rep_fl & fl;
		end
	end

	// (R10) stop entry request held until served
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			mode_q <= eip_pkg::EIP_MODE_INIT;
			stop_req <= 1'b0;
		end else begin
			mode_q <= i_mode;
			stop_req <= stop_entry || (stop_req && !fire);
		end
	end

	// (R01) (R02) pulse then minimum high gap; (R03) mode is input only
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			state <= eip_pkg::EIP_ST_IDLE;
			cnt <= '0;
		end else begin
			case (state)
				eip_pkg::EIP_ST_IDLE: begin
					cnt <= '0;
					if (fire) begin
						state <= eip_pkg::EIP_ST_PULSE;
					end
				end
				eip_pkg::EIP_ST_PULSE: begin
					cnt <= pulse_end ? '0 : cnt + CW'(1);
					if (pulse_end) begin
						state <= eip_pkg::EIP_ST_GAP;
					end
				end
				eip_pkg::EIP_ST_GAP: begin
					cnt <= gap_end ? '0 : cnt + CW'(1);
					if (gap_end) begin
						state <= eip_pkg::EIP_ST_IDLE;
					end
				end
				default: begin
					state <= eip_pkg::EIP_ST_IDLE;
					cnt <= '0;
				end
			endcase
		end
	end

	// pin drive: low during pulse, high otherwise; released in init mode
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			o_int_out <= 1'b1;
			o_int_oe <= 1'b0;
			o_int_pd_en <= 1'b1;
		end else begin
			o_int_out <= !(fire || (state == eip_pkg::EIP_ST_PULSE && !pulse_end));
			// (R14) init mode senses the pin through the pull-down
			o_int_oe <= !init_mode;
			o_int_pd_en <= init_mode;
		end
	end

	// (R11) host view snapshot at each falling edge of the pulse
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			o_wake_status_a <= '0;
			o_wake_status_b <= '0;
			o_bus_timeout_status <= 1'b0;
			o_fail_status <= '0;
		end else if (fire) begin
			o_wake_status_a <= wk_a;
			o_wake_status_b <= wk_b;
			o_bus_timeout_status <= bto;
			o_fail_status <= fl;
		end else begin
			// (R12) host clears take effect on the view
			o_wake_status_a <= o_wake_status_a & wk_a;
			o_wake_status_b <= o_wake_status_b & wk_b;
			o_bus_timeout_status <= o_bus_timeout_status & bto;
			o_fail_status <= o_fail_status & fl;
		end
	end

	// (R14) (R15) filtered config select level
	eip_cfg_filter #(
		.FLT_CYC(CFG_FLT_CYC),
		.CNT_W(CW)
	) u_cfg (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_enable(init_mode),
		.i_level(i_int_pin),
		.o_level(o_cfg_sel)
	);

	// pin run lengths for the timing checks; the high run saturates while idle
	logic [CW-1:0] low_run;
	logic [CW-1:0] high_run;
	wire logic [CW-1:0] next_low_run = o_int_out ? '0 : low_run + CW'(1);
	wire logic [CW-1:0] next_high_run = !o_int_out ? '0 : ((&high_run) ? high_run : high_run + CW'(1));
	// count cycles since the pin last changed level
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			low_run <= '0;
			high_run <= '1;
		end else begin
			low_run <= next_low_run;
			high_run <= next_high_run;
		end
	end

	sequence s_fall;
		$fell(o_int_out);
	endsequence
	sequence s_rise;
		$rose(o_int_out);
	endsequence
	// (R01) fall starts the pulse timer
	pulse_start_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R01
		s_fall |-> state == eip_pkg::EIP_ST_PULSE) else $error("fall without pulse state");
	// (R01) pulse low exactly PULSE_CYC cycles
	pulse_width_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R01
		s_rise |-> low_run == CW'(PULSE_CYC)) else $error("pulse width wrong");
	// (R02) no new fall before the gap elapsed
	gap_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R02
		s_fall |-> high_run >= CW'(GAP_CYC)) else $error("gap too short");
	// (R02) pin high in gap
	gap_state_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R02
		state == eip_pkg::EIP_ST_GAP |-> o_int_out) else $error("pin low in gap");
	// (R04) class 0 ignores failures
	class_wake_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R04
		fire && !i_int_global |-> wake_new || bto_new || stop_req) else $error("failure fired in wake class");
	// (R06) masked timeout never fires alone
	bto_mask_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R06
		fire && i_bus_timeout_irq_mask && !wake_new && !stop_req |-> fail_new) else $error("masked timeout fired");
	// (R10) stop entry request kept
	stop_irq_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R10
		stop_entry |=> stop_req) else $error("stop entry lost");
	// (R11) snapshot taken with the fall
	status_snap_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R11
		fire |=> o_wake_status_a == $past(wk_a)) else $error("status not updated at fall");
	// (R12) uncleared flag stays set
	flag_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R12
		wk_a[0] && !i_clr_wake_a[0] |=> wk_a[0]) else $error("flag dropped without clear");
	// (R14) pin released in init
	init_release_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R14
		init_mode |=> !o_int_oe) else $error("pin driven in init");
endmodule

// >>> verif/eip_host_model.sv
// host model: times the interrupt pin, reads and clears the status view
`timescale 1ns/100ps
module eip_host_model (
	input wire logic i_mclk,
	input wire logic i_pin,
	input wire logic i_auto_clr,
	input wire logic [24:0] i_stat,
	output logic [24:0] o_clr,
	output logic [24:0] o_seen,
	output logic [24:0] o_reread,
	output int o_pulses,
	output int o_low,
	output int o_gap
);
	logic pin_q; // pin level at the last edge
	int run; // samples since the pin last changed
	// start with the pin seen high and nothing cleared
	initial begin
		pin_q = 1'b1;
		run = 0;
		o_pulses = 0;
		o_clr = 25'h0000000;
	end
	// width and gap counted in samples, status taken at each fall
	always @(posedge i_mclk) begin
		pin_q <= i_pin;
		run <= (i_pin !== pin_q) ? 1 : run + 1;
		if (pin_q && !i_pin) begin
			o_pulses <= o_pulses + 1;
			o_gap <= run;
			o_seen <= i_stat;
		end
		if (!pin_q && i_pin) begin
			o_low <= run;
		end
	end
	always @(posedge i_mclk) begin
		o_clr <= i_auto_clr ? i_stat : 25'h0000000;
		o_reread <= i_stat & o_clr;
	end
endmodule

// >>> verif/tb_eip_pulser.sv
// testbench for the event interrupt pulser with a host model on the pin
`timescale 1ns/100ps
module tb_eip_pulser;
	logic i_mclk; // 50 MHz system clock
	logic i_rst_b; // synchronous reset, active low
	eip_pkg::eip_mode_t i_mode; // operating mode
	logic i_int_global, i_bus_timeout_flag, i_bus_timeout_irq_mask;
	logic [7:0] i_wake_evt_a, i_wake_evt_b, i_wake_en_a, i_wake_en_b, i_fail_evt;
	logic cfg_drv, auto_clr; // board level on the pin, host clearing on
	logic o_int_out, o_int_oe, o_int_pd_en, o_cfg_sel, o_bus_timeout_status;
	logic [7:0] o_wake_status_a, o_wake_status_b, o_fail_status;
	logic [24:0] clr, seen, reread; // host clears and snapshots
	int pulses, low, gap, exp_p;
	int fails = 0;
	int n_checks = 0;
	wire logic int_pin; // resolved pin level
	assign int_pin = o_int_oe ? o_int_out : cfg_drv;
	eip_pulser #(.PULSE_CYC(20), .GAP_CYC(20), .CFG_FLT_CYC(8)) i_eip_pulser (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
		.i_mode(i_mode), .i_int_global(i_int_global), .i_wake_evt_a(i_wake_evt_a), .i_wake_evt_b(i_wake_evt_b),
		.i_wake_en_a(i_wake_en_a), .i_wake_en_b(i_wake_en_b), .i_clr_wake_a(clr[7:0]), .i_clr_wake_b(clr[15:8]),
		.i_bus_timeout_flag(i_bus_timeout_flag), .i_bus_timeout_irq_mask(i_bus_timeout_irq_mask),
		.i_clr_bus_timeout(clr[24]), .i_fail_evt(i_fail_evt), .i_clr_fail(clr[23:16]), .i_int_pin(int_pin),
		.o_int_out(o_int_out), .o_int_oe(o_int_oe), .o_int_pd_en(o_int_pd_en), .o_cfg_sel(o_cfg_sel),
		.o_wake_status_a(o_wake_status_a), .o_wake_status_b(o_wake_status_b),
		.o_bus_timeout_status(o_bus_timeout_status), .o_fail_status(o_fail_status));
	eip_host_model i_eip_host_model (.i_mclk(i_mclk), .i_pin(int_pin), .i_auto_clr(auto_clr),
		.i_stat({o_bus_timeout_status, o_fail_status, o_wake_status_b, o_wake_status_a}), .o_clr(clr),
		.o_seen(seen), .o_reread(reread), .o_pulses(pulses), .o_low(low), .o_gap(gap));
	// clock generator
	initial begin
		i_mclk = 1'b0;
		forever #10 i_mclk = ~i_mclk;
	end
	// compare one result
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	endtask
	// print counts and verdict, then stop
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic idle(input int c);
		repeat (c) @(negedge i_mclk);
	endtask
	// one-cycle event on {timeout, fail, wake b, wake a}
	task automatic fire(input logic [24:0] v);
		@(negedge i_mclk);
		{i_bus_timeout_flag, i_fail_evt, i_wake_evt_b, i_wake_evt_a} = v;
		@(negedge i_mclk);
		{i_bus_timeout_flag, i_fail_evt, i_wake_evt_b, i_wake_evt_a} = 25'h0000000;
	endtask
	// wait a bounded time for more pulses, then let pulse and gap run out
	task automatic expect_p(input int add);
		exp_p += add;
		for (int k = 0; k < 80 && pulses < exp_p; k++) @(negedge i_mclk);
		idle(45);
		chk("pulse count", exp_p, pulses);
	endtask
	// watchdog
	initial begin
		repeat (5000) @(posedge i_mclk);
		fails++;
		end_sim();
	end
	// main sequence
	initial begin
		{i_rst_b, i_int_global, i_bus_timeout_flag, cfg_drv} = 4'h0;
		{i_wake_evt_a, i_wake_evt_b, i_fail_evt} = 24'h000000;
		{i_wake_en_a, i_wake_en_b} = 16'hff7f;
		{i_bus_timeout_irq_mask, auto_clr} = 2'h3;
		i_mode = eip_pkg::EIP_MODE_INIT;
		exp_p = 0;
		idle(8);
		chk("reset pin", 3'h5, {o_int_out, o_int_oe, o_int_pd_en});
		i_rst_b = 1'b1;
		cfg_drv = 1'b1;
		idle(4);
		chk("cfg early", 1'b0, o_cfg_sel);
		idle(12);
		chk("cfg sel", 2'h1, {o_int_oe, o_cfg_sel});
		i_mode = eip_pkg::EIP_MODE_NORMAL;
		idle(4);
		chk("pin drive", 2'h2, {o_int_oe, o_int_pd_en});
		exp_p = pulses;
		fire(25'h0000001);
		expect_p(1);
		chk("pulse width", 20, low);
		chk("status at fall", 25'h0000001, seen);
		fire(25'h0000100);
		expect_p(1);
		fire(25'h0000002);
		fire(25'h0000004);
		expect_p(2);
		// back to back: the gap timer plus the idle cycle that starts the next pulse
		chk("gap", 21, gap);
		chk("pending status", 8'h04, seen[7:0]);
		fire(25'h0008000);
		expect_p(0);
		i_bus_timeout_irq_mask = 1'b0;
		fire(25'h1000000);
		expect_p(1);
		{i_bus_timeout_irq_mask, i_int_global} = 2'h3;
		fire(25'h1000000);
		expect_p(0);
		fire(25'h0010000);
		expect_p(1);
		chk("fail status", 8'h01, seen[23:16]);
		i_int_global = 1'b0;
		fire(25'h0020000);
		expect_p(0);
		auto_clr = 1'b0;
		fire(25'h0000008);
		expect_p(1);
		idle(100);
		chk("held flag", 8'h08, o_wake_status_a);
		i_mode = eip_pkg::EIP_MODE_STOP;
		expect_p(1);
		auto_clr = 1'b1;
		idle(5);
		chk("cleared", 8'h00, o_wake_status_a);
		chk("reread", 25'h0000000, reread);
		// no pulse in sleep mode; the flag waits and fires once normal again
		i_mode = eip_pkg::EIP_MODE_SLEEP;
		fire(25'h0000010);
		expect_p(0);
		i_mode = eip_pkg::EIP_MODE_NORMAL;
		expect_p(1);
		end_sim();
	end
endmodule
